// ===== verilog/wake_reset_pkg.sv
package wake_reset_pkg;

  // register byte offsets
  localparam logic [11:0] OFF_WAKE_ENABLE = 12'h188;
  localparam logic [11:0] OFF_BUS_CONFIG  = 12'h3F8;
  localparam logic [11:0] OFF_REVISION    = 12'h3FC;

  // wake enable layout
  localparam int          WAKE_BITS       = 7;
  localparam int          BIT_TOUCH       = 0;
  localparam int          BIT_COMPARATOR  = 1;
  localparam int          BIT_CONVERTER   = 2;
  localparam int          BIT_TWS_ZERO    = 3;
  localparam int          BIT_TWS_ONE     = 4;
  localparam int          BIT_WAKE_PIN    = 5;
  localparam int          BIT_PEN_DETECT  = 6;
  localparam logic [31:0] WAKE_EN_RESET   = 32'h0000_0000;

  // capability layout
  localparam int          BIT_BUS_A       = 0;
  localparam int          BIT_BUS_D       = 3;
  localparam int          BIT_EVENT_CLK   = 7;

  // revision layout
  localparam int          VERSION_LSB     = 0;
  localparam int          VERSION_W       = 12;
  localparam int          VARIANT_LSB     = 16;
  localparam int          VARIANT_W       = 4;

  // pin synchroniser depth
  localparam int          SYNC_STAGES     = 2;

  // one-cycle reset event pulses from the reset controller
  typedef struct packed {
    logic power_on;
    logic external;
    logic watchdog;
    logic brown_out;
    logic supply_mon;
    logic cpu_error;
    logic debug_req;
    logic test_port;
  } reset_cause_t;

  // per-domain clear strobes
  typedef struct packed {
    logic core;
    logic timer_regs;
    logic osc32k;
    logic rc_cal;
    logic volt_cal;
    logic osc_ctrl;
    logic wdog_ctrl;
    logic supply_ctrl;
    logic brown_ctrl;
    logic clock_ctrl;
    logic debug_sys;
  } reset_scope_t;

  localparam reset_scope_t SCOPE_IDLE = '0;

endpackage : wake_reset_pkg

// ===== verilog/wake_enable_reset_scope.sv
// How it works
// RULE_01: wake enable word at 0x188, bits 0..6 select seven sources, rest unused.
// RULE_02: a wake request passes only while its enable bit is one.
// RULE_03: read-only capability word: bit 7 event clock, bits 3..0 buses D..A.
// RULE_04: read-only revision word carries a 12-bit version in bits 11..0.
// RULE_05: variant field bits 19..16 is reserved with no behaviour.
// RULE_06: timer, 32 kHz oscillator and voltage calibration clear on power-on only.
// RULE_07: RC calibration restores on power-on only, kept across all other resets.
// RULE_08: debug system clears on every reset except watchdog and debug-requested.
// RULE_09: non-32 kHz oscillator controls clear on every reset cause.
// RULE_10: register interface runs on the dedicated power manager bus clock.
//
// The APB interface to the registers was decided locally.
module wake_enable_reset_scope #(
  parameter int          NUM_WAKE   = 7,
  parameter logic [3:0]  BUS_PRESENT = 4'hF,
  parameter logic        EVENT_CLK  = 1'b1,
  // arbitrary revision values
  parameter logic [11:0] VERSION    = 12'h101,
  parameter logic [3:0]  VARIANT    = 4'h0
) (
  // clock, reset, enable
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          clk_en,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [11:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // asynchronous wake requests from sources
  input  wire logic [NUM_WAKE-1:0]           wake_request,
  output logic      [NUM_WAKE-1:0]           wake_granted,
  output logic                               wake_any,
  // reset events and their scope
  input  wire wake_reset_pkg::reset_cause_t  reset_event,
  output wake_reset_pkg::reset_scope_t       reset_scope
);

  generate
    if (NUM_WAKE != wake_reset_pkg::WAKE_BITS)
    begin : g_bad_width
      $error("wake source count must match the enable layout");
    end
  endgenerate

  logic [NUM_WAKE-1:0] async_wake_enable;
  logic [NUM_WAKE-1:0] wake_sync1;
  logic [NUM_WAKE-1:0] wake_sync2;
  logic                setup;
  logic                access;
  logic                hit_wake;
  logic                hit_cfg;
  logic                hit_rev;
  logic [31:0]         next_prdata;
  logic [31:0]         bus_presence_config;
  logic [31:0]         module_revision;
  logic                any_reset;

  // all registers sit on pclk, the power manager bus clock  (see RULE_10)
  assign setup    = psel && !penable;
  assign access   = psel && penable && pready;
  assign hit_wake = paddr == wake_reset_pkg::OFF_WAKE_ENABLE;
  assign hit_cfg  = paddr == wake_reset_pkg::OFF_BUS_CONFIG;
  assign hit_rev  = paddr == wake_reset_pkg::OFF_REVISION;

  // capability word is wired from parameters  (see RULE_03)
  always_comb
  begin
    bus_presence_config = '0;
    bus_presence_config[wake_reset_pkg::BIT_BUS_D:wake_reset_pkg::BIT_BUS_A] = BUS_PRESENT;
    bus_presence_config[wake_reset_pkg::BIT_EVENT_CLK] = EVENT_CLK;
  end

  // variant is reported only, nothing looks at it  (see RULE_05)
  always_comb
  begin
    module_revision = '0;
    module_revision[wake_reset_pkg::VERSION_LSB +: wake_reset_pkg::VERSION_W] = VERSION; // see RULE_04
    module_revision[wake_reset_pkg::VARIANT_LSB +: wake_reset_pkg::VARIANT_W] = VARIANT; // see RULE_05
  end

  // unused bits above the seven sources read zero  (see RULE_01)
  always_comb
  begin
    next_prdata = '0;
    if (hit_wake)
      next_prdata[NUM_WAKE-1:0] = async_wake_enable;
    else if (hit_cfg)
      next_prdata = bus_presence_config;
    else if (hit_rev)
      next_prdata = module_revision;
  end

  // no wait state: answer is prepared in setup, handed over in the first access cycle
  // limitation: keep clk_en high from setup to access, else a frozen pready ends the transfer early
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else if (clk_en)
    begin
      pready  <= setup;
      pslverr <= setup && !(hit_wake || hit_cfg || hit_rev);
      prdata  <= (setup && !pwrite) ? next_prdata : '0;
    end
  end

  // only lane 0 carries writable bits; read-only words ignore writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      async_wake_enable <= wake_reset_pkg::WAKE_EN_RESET[NUM_WAKE-1:0]; // see RULE_01
    else if (clk_en && access && pwrite && hit_wake && pstrb[0])
      async_wake_enable <= pwdata[NUM_WAKE-1:0]; // see RULE_01
  end

  // wake pins are asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_sync1 <= '0;
      wake_sync2 <= '0;
    end
    else if (clk_en)
    begin
      wake_sync1 <= wake_request;
      wake_sync2 <= wake_sync1;
    end
  end

  // a disabled source is dropped here, before anything else sees it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_granted <= '0;
      wake_any     <= 1'b0;
    end
    else if (clk_en)
    begin
      wake_granted <= wake_sync2 & async_wake_enable; // see RULE_02
      wake_any     <= |(wake_sync2 & async_wake_enable); // see RULE_02
    end
  end

  assign any_reset = |reset_event;

  // strobes follow the event by one cycle; they are decoded, not stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reset_scope <= wake_reset_pkg::SCOPE_IDLE;
    else if (clk_en)
    begin
      reset_scope.core        <= any_reset;
      reset_scope.timer_regs  <= reset_event.power_on; // see RULE_06
      reset_scope.osc32k      <= reset_event.power_on; // see RULE_06
      reset_scope.volt_cal    <= reset_event.power_on; // see RULE_06
      reset_scope.rc_cal      <= reset_event.power_on; // see RULE_07
      reset_scope.osc_ctrl    <= any_reset; // see RULE_09
      reset_scope.wdog_ctrl   <= any_reset && !reset_event.watchdog;
      reset_scope.supply_ctrl <= any_reset;
      reset_scope.brown_ctrl  <= any_reset && !reset_event.brown_out;
      reset_scope.clock_ctrl  <= any_reset;
      reset_scope.debug_sys   <= any_reset && !reset_event.watchdog
                                 && !reset_event.debug_req; // see RULE_08
    end
  end

  // a write in access lands in the enable word at the next edge
  a_wake_en_write: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_01
    clk_en && access && pwrite && hit_wake && pstrb[0]
    |=> async_wake_enable == $past(pwdata[NUM_WAKE-1:0]))
    else $error("wake enable write not stored");

  a_wake_en_hold: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_01
    !(access && pwrite && hit_wake) |=> $stable(async_wake_enable))
    else $error("wake enable changed without a write");

  a_wake_blocked: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_02
    clk_en && (wake_sync2 & ~async_wake_enable) != '0
    |=> (wake_granted & ~$past(async_wake_enable)) == '0)
    else $error("disabled wake source passed");

  a_wake_passes: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_02
    clk_en && (wake_sync2 & async_wake_enable) != '0 |=> wake_any)
    else $error("enabled wake source lost");

  a_cfg_read: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_03
    clk_en && setup && !pwrite && hit_cfg
    |=> pready && prdata[7] == EVENT_CLK && prdata[3:0] == BUS_PRESENT && prdata[6:4] == 3'h0)
    else $error("capability read wrong");

  a_rev_read: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_04
    clk_en && setup && !pwrite && hit_rev
    |=> pready && prdata[11:0] == VERSION && prdata[15:12] == 4'h0)
    else $error("revision read wrong");

  a_variant_field: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_05
    clk_en && setup && !pwrite && hit_rev |=> prdata[19:16] == VARIANT && prdata[31:20] == 12'h000)
    else $error("variant field wrong");

  a_por_only: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_06
    clk_en && any_reset && !reset_event.power_on
    |=> !reset_scope.timer_regs && !reset_scope.osc32k && !reset_scope.volt_cal)
    else $error("power-on-only state cleared by another reset");

  a_por_clears: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_06
    clk_en && reset_event.power_on
    |=> reset_scope.timer_regs && reset_scope.osc32k && reset_scope.volt_cal)
    else $error("power-on reset missed a clear");

  a_rc_cal_kept: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_07
    clk_en |=> reset_scope.rc_cal == $past(reset_event.power_on))
    else $error("rc calibration restore wrong");

  a_debug_scope: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_08
    clk_en && (reset_event.watchdog || reset_event.debug_req) |=> !reset_scope.debug_sys)
    else $error("debug system cleared by watchdog or debug reset");

  a_osc_ctrl_all: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_09
    clk_en && any_reset |=> reset_scope.osc_ctrl ##1 (reset_scope.osc_ctrl == $past(any_reset) || !$past(clk_en)))
    else $error("oscillator controls not cleared");

  a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_10
    clk_en && setup |=> pready && !$past(pready))
    else $error("apb answer not one cycle after setup");

  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_10
    clk_en && setup && !(hit_wake || hit_cfg || hit_rev)
    |=> pready && pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  a_mapped_ok: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_10
    clk_en && setup && (hit_wake || hit_cfg || hit_rev) |=> pready && !pslverr)
    else $error("mapped access flagged as error");

  a_write_rdata_zero: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_10
    clk_en && setup && pwrite |=> prdata == 32'h0000_0000)
    else $error("write answered with read data");

  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_10
    clk_en && pready |=> !pready)
    else $error("pready stood more than one cycle");

  a_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_10
    clk_en && !setup |=> !pready && !pslverr && prdata == 32'h0000_0000)
    else $error("answer without a setup cycle");

  a_bus_frozen: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_10
    !clk_en |=> $stable(pready) && $stable(pslverr) && $stable(prdata))
    else $error("bus answer moved while clock enable low");

  a_wake_read: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_01
    clk_en && setup && !pwrite && hit_wake
    |=> prdata[NUM_WAKE-1:0] == $past(async_wake_enable) && prdata[31:NUM_WAKE] == '0)
    else $error("wake enable read wrong");

  a_strobe_ignored: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_01
    access && pwrite && hit_wake && !pstrb[0] |=> $stable(async_wake_enable))
    else $error("wake enable written with lane 0 off");

  a_other_writes: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_01
    access && pwrite && !hit_wake |=> $stable(async_wake_enable))
    else $error("wake enable changed by another address");

  a_wake_frozen: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_02
    !clk_en |=> $stable(async_wake_enable) && $stable(wake_granted) && $stable(wake_any))
    else $error("wake state moved while clock enable low");

  a_sync_chain: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_02
    clk_en |=> wake_sync2 == $past(wake_sync1))
    else $error("synchroniser stage skipped");

  a_grant_exact: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_02
    clk_en |=> wake_granted == ($past(wake_sync2) & $past(async_wake_enable)))
    else $error("granted word not request and enable");

  a_any_follows: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_02
    wake_any == (|wake_granted))
    else $error("wake summary disagrees with granted word");

  a_any_blocked: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_02
    clk_en && (wake_sync2 & async_wake_enable) == '0 |=> !wake_any)
    else $error("wake raised with no enabled request");

  a_cfg_upper: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_03
    clk_en && setup && !pwrite && hit_cfg |=> prdata[31:8] == 24'h000000)
    else $error("capability upper bits not zero");

  a_scope_frozen: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_09
    !clk_en |=> $stable(reset_scope))
    else $error("reset strobes moved while clock enable low");

  a_timer_exact: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_06
    clk_en |=> reset_scope.timer_regs == $past(reset_event.power_on))
    else $error("timer clear strobe wrong");

  a_osc32k_exact: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_06
    clk_en |=> reset_scope.osc32k == $past(reset_event.power_on))
    else $error("32 kHz oscillator clear strobe wrong");

  a_volt_exact: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_06
    clk_en |=> reset_scope.volt_cal == $past(reset_event.power_on))
    else $error("voltage calibration clear strobe wrong");

  a_por_quiet: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_06
    clk_en && !reset_event.power_on
    |=> !reset_scope.timer_regs && !reset_scope.osc32k && !reset_scope.volt_cal)
    else $error("power-on-only strobe without power-on");

  a_rc_cal_por: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_07
    clk_en && reset_event.power_on |=> reset_scope.rc_cal)
    else $error("rc calibration not restored on power-on");

  a_rc_cal_other: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_07
    clk_en && any_reset && !reset_event.power_on |=> !reset_scope.rc_cal)
    else $error("rc calibration restored by another reset");

  a_debug_clears: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_08
    clk_en && any_reset && !reset_event.watchdog && !reset_event.debug_req
    |=> reset_scope.debug_sys)
    else $error("debug system not reset");

  a_debug_quiet: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_08
    clk_en && !any_reset |=> !reset_scope.debug_sys)
    else $error("debug reset strobe without a reset");

  a_osc_ctrl_exact: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_09
    clk_en |=> reset_scope.osc_ctrl == $past(any_reset))
    else $error("oscillator control strobe wrong");

  a_osc_ctrl_por: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_09
    clk_en && reset_event.power_on |=> reset_scope.osc_ctrl)
    else $error("power-on reset missed oscillator controls");

  a_osc_ctrl_kept: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_09
    clk_en && (reset_event.watchdog || reset_event.brown_out || reset_event.debug_req) |=> reset_scope.osc_ctrl)
    else $error("watchdog, brown-out or debug reset missed oscillator controls");

endmodule : wake_enable_reset_scope

// ===== dv/tb_wake_enable_reset_scope.sv
module tb_wake_enable_reset_scope;
  timeunit 1ns;
  timeprecision 1ps;

  // arbitrary identity and capability values
  localparam logic [11:0] TB_VERSION = 12'hA5C;
  localparam logic [3:0]  TB_VARIANT = 4'h3;
  localparam logic [3:0]  TB_BUSES   = 4'h5;
  localparam logic        TB_EVCLK   = 1'b1;

  logic                          pclk = 1'b0;
  logic                          presetn = 1'b0;
  logic                          clk_en = 1'b1;
  logic                          psel = 1'b0;
  logic                          penable = 1'b0;
  logic                          pwrite = 1'b0;
  logic [11:0]                   paddr = 12'h000;
  logic [31:0]                   pwdata = 32'h0;
  logic [3:0]                    pstrb = 4'h0;
  logic [31:0]                   prdata;
  logic                          pready;
  logic                          pslverr;
  logic [6:0]                    wake_request = 7'h00;
  logic [6:0]                    wake_granted;
  logic                          wake_any;
  wake_reset_pkg::reset_cause_t  reset_event = '0;
  wake_reset_pkg::reset_scope_t  reset_scope;
  logic [32:0]                   rq[$];
  logic [32:0]                   sq[$];
  int                            err_total = 0;
  int                            n_tests = 0;
  logic [31:0]                   en;
  logic [6:0]                    rr;
  wake_reset_pkg::reset_scope_t  es;

  always #2 pclk = ~pclk;

  wake_enable_reset_scope #(.NUM_WAKE(7), .BUS_PRESENT(TB_BUSES), .EVENT_CLK(TB_EVCLK),
    .VERSION(TB_VERSION), .VARIANT(TB_VARIANT)) DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .wake_request(wake_request),
    .wake_granted(wake_granted), .wake_any(wake_any), .reset_event(reset_event), .reset_scope(reset_scope));

  task check(input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task conclude;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  // the whole answer word is noted, so a stray error flag on a good access is caught too
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
           input logic [31:0] ex, input logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    rq.push_back({ex, er});
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (n == 20)
    begin
      err_total++;
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  always @(posedge pclk)
  begin
    if (pready === 1'b1 && rq.size() > 0)
      check({prdata, pslverr}, rq.pop_front());
    if (reset_scope !== wake_reset_pkg::SCOPE_IDLE && sq.size() > 0)
      check(33'(reset_scope), sq.pop_front());
  end

  initial
  begin
    void'($urandom(19139));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, wake_reset_pkg::OFF_WAKE_ENABLE, 32'h0, 4'h0, wake_reset_pkg::WAKE_EN_RESET, 1'b0);
    apb(1'b1, wake_reset_pkg::OFF_WAKE_ENABLE, 32'hFFFF_FFFF, 4'h0, 32'h0, 1'b0);
    apb(1'b0, wake_reset_pkg::OFF_WAKE_ENABLE, 32'h0, 4'h0, 32'h0, 1'b0);
    $display("wake enable reset and strobe done");
    apb(1'b1, wake_reset_pkg::OFF_BUS_CONFIG, 32'hFFFF_FFFF, 4'hF, 32'h0, 1'b0);
    apb(1'b0, wake_reset_pkg::OFF_BUS_CONFIG, 32'h0, 4'h0, {24'h0, TB_EVCLK, 3'h0, TB_BUSES}, 1'b0);
    apb(1'b1, wake_reset_pkg::OFF_REVISION, 32'hFFFF_FFFF, 4'hF, 32'h0, 1'b0);
    apb(1'b0, wake_reset_pkg::OFF_REVISION, 32'h0, 4'h0, {12'h0, TB_VARIANT, 4'h0, TB_VERSION}, 1'b0);
    apb(1'b0, 12'h18C, 32'h0, 4'h0, 32'h0, 1'b1);
    apb(1'b1, 12'h3F4, 32'h1, 4'hF, 32'h0, 1'b1);
    $display("read-only and unmapped done");
    // enable and request patterns are random, so each source meets both enable states
    repeat (10)
    begin
      en = $urandom();
      rr = 7'($urandom());
      apb(1'b1, wake_reset_pkg::OFF_WAKE_ENABLE, en, 4'hF, 32'h0, 1'b0);
      apb(1'b0, wake_reset_pkg::OFF_WAKE_ENABLE, 32'h0, 4'h0, {25'h0, en[6:0]}, 1'b0);
      @(posedge pclk);
      wake_request <= rr;
      repeat (4) @(posedge pclk);
      check(33'(wake_granted), 33'(rr & en[6:0]));
      check(33'(wake_any), 33'(|(rr & en[6:0])));
    end
    $display("wake gating done");
    // a low clock enable must hold the granted word while the requests move
    @(posedge pclk);
    clk_en <= 1'b0;
    wake_request <= ~rr;
    repeat (4) @(posedge pclk);
    check(33'(wake_granted), 33'(rr & en[6:0]));
    clk_en <= 1'b1;
    repeat (4) @(posedge pclk);
    check(33'(wake_granted), 33'(~rr & en[6:0]));
    check(33'(wake_any), 33'(|(~rr & en[6:0])));
    $display("clock enable freeze done");
    for (int i = 0; i < 8; i++)
    begin
      es = wake_reset_pkg::SCOPE_IDLE;
      es.core = 1'b1;
      es.timer_regs = (i == 0);
      es.osc32k = (i == 0);
      es.rc_cal = (i == 0);
      es.volt_cal = (i == 0);
      es.osc_ctrl = 1'b1;
      es.wdog_ctrl = (i != 2);
      es.supply_ctrl = 1'b1;
      es.brown_ctrl = (i != 3);
      es.clock_ctrl = 1'b1;
      es.debug_sys = (i != 2) && (i != 6);
      sq.push_back(33'(es));
      @(posedge pclk);
      reset_event <= wake_reset_pkg::reset_cause_t'(8'h80 >> i);
      @(posedge pclk);
      reset_event <= '0;
      repeat (3) @(posedge pclk);
    end
    check(33'(sq.size()), 33'h0);
    check(33'(rq.size()), 33'h0);
    $display("reset scope table done");
    conclude();
  end
endmodule : tb_wake_enable_reset_scope
